// *** core/fc_cmd_core.sv ***
/*
 * Command-phase interpreter of the floppy controller: takes command
 * bytes from the host, runs the control commands, hands seeks and data
 * transfers to the positioner and the transfer engine, returns results.
 * Assumes host strobes, positioner and engine run on ref_clk; drive
 * status pins are asynchronous.
 */
// Behaviour
// - Sense interrupt with one pending returns status zero then the present cylinder.
// - Sense drive takes head/drive byte, returns selected drive status.
// - Seek takes head/drive byte and target cylinder, moves the head.
// - Read ID stores first valid sector ID, returns final status.
// - Unknown opcode is a no-op returning one byte 80H.
// - Dump returns sector count after format, final sector after transfer.
// - Drive select bits in commands never drive external select pins.
// - Read, write, verify share parameter and result layouts.
// - Implied seek enabled makes transfers seek to the cylinder first when it differs from the present one.
// - Drive busy flag is set during the implied seek.
// - Failed implied seek reports error and failing cylinder in results.
// - Head settle time waited before a transfer starts reading IDs.
`timescale 1ns/1ps
`default_nettype none
module fc_cmd_core #(
  parameter int SETTLE_UNIT_CYC = fc_pkg::FC_SETTLE_UNIT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  input wire logic res_rd,
  output logic res_avail,
  output logic [7:0] res_data,
  output logic ctrl_busy,
  output logic [3:0] drive_busy,
  output logic int_pending,
  input wire logic [3:0] write_protect_pin,
  input wire logic [3:0] drive_ready_pin,
  input wire logic [3:0] track_zero_pin,
  output logic seek_req,
  output logic [1:0] seek_drive,
  output logic [7:0] seek_cyl,
  input wire logic seek_done,
  input wire logic seek_fail,
  input wire logic [7:0] seek_fail_cyl,
  output logic exec_req,
  output logic [7:0] exec_opcode,
  output logic [7:0] exec_select,
  output logic [7:0] exec_cyl,
  output logic [7:0] exec_head,
  output logic [7:0] exec_sector,
  output logic [7:0] exec_size,
  output logic [7:0] exec_final,
  input wire logic exec_done,
  input wire logic [7:0] exec_st0,
  input wire logic [7:0] exec_st1,
  input wire logic [7:0] exec_st2,
  input wire logic [7:0] exec_c,
  input wire logic [7:0] exec_h,
  input wire logic [7:0] exec_r,
  input wire logic [7:0] exec_n,
  output logic implied_seek_enable,
  output logic [7:0] config_byte,
  output logic [3:0] step_rate_time,
  output logic [6:0] head_load_time,
  output logic lock_state
);
  typedef enum logic [2:0] {
    S_IDLE, S_PARAM, S_DISPATCH, S_SEEK, S_SETTLE, S_EXEC, S_RES
  } fc_state_t;

  fc_state_t state_r, state_nxt;
  logic [7:0] prm_r [0:8];
  logic [7:0] prm_nxt [0:8];
  logic [7:0] res_r [0:9];
  logic [7:0] res_nxt [0:9];
  logic [7:0] pcn_r [0:3];
  logic [7:0] pcn_nxt [0:3];
  fc_pkg::fc_cmd_t kind_r, kind_nxt;
  logic [3:0] cnt_r, cnt_nxt, len_r, len_nxt, idx_r, idx_nxt;
  logic [7:0] spec1_r, spec1_nxt, spec2_r, spec2_nxt;
  logic [7:0] cfg_r, cfg_nxt, pretrk_r, pretrk_nxt, perp_r, perp_nxt;
  logic [7:0] sc_r, sc_nxt, eot_r, eot_nxt, st0p_r, st0p_nxt;
  logic [7:0] res_data_r, res_data_nxt, seek_cyl_r, seek_cyl_nxt;
  logic last_fmt_r, last_fmt_nxt, lock_r, lock_nxt, pend_r, pend_nxt;
  logic go_xfer_r, go_xfer_nxt;
  logic [1:0] drv_r, drv_nxt, pdrv_r, pdrv_nxt;
  logic [22:0] settle_r, settle_nxt;
  logic [3:0] wp_m, wp_s, rdy_m, rdy_s, t0_m, t0_s;
  logic [1:0] sel_drv;
  logic sel_head;

  function automatic fc_pkg::fc_cmd_t classify(input logic [7:0] op);
    if (op == fc_pkg::FC_OP_SEEK) return fc_pkg::FC_SEEK;
    if (op == fc_pkg::FC_OP_RECAL) return fc_pkg::FC_RECAL;
    if (op == fc_pkg::FC_OP_SENSE_INT) return fc_pkg::FC_SENSE_INT;
    if (op == fc_pkg::FC_OP_SENSE_DRV) return fc_pkg::FC_SENSE_DRV;
    if (op == fc_pkg::FC_OP_SPECIFY) return fc_pkg::FC_SPECIFY;
    if (op == fc_pkg::FC_OP_CONFIGURE) return fc_pkg::FC_CONFIGURE;
    if (op == fc_pkg::FC_OP_DUMPREG) return fc_pkg::FC_DUMPREG;
    if (op == fc_pkg::FC_OP_PERP) return fc_pkg::FC_PERP;
    if (op == fc_pkg::FC_OP_VERSION) return fc_pkg::FC_VERSION;
    if (op[6:0] == fc_pkg::FC_OP_LOCK) return fc_pkg::FC_LOCK;
    if (op[7] == 1'b0 && op[5:0] == fc_pkg::FC_OP_READ_ID)
      return fc_pkg::FC_READ_ID;
    if (op[7] == 1'b0 && op[5:0] == fc_pkg::FC_OP_FORMAT)
      return fc_pkg::FC_FORMAT;
    // Transfer family differs only in the low five bits
    case (op[4:0])
      fc_pkg::FC_OP_READ, fc_pkg::FC_OP_READ_DEL, fc_pkg::FC_OP_WRITE,
      fc_pkg::FC_OP_WRITE_DEL, fc_pkg::FC_OP_READ_TRK,
      fc_pkg::FC_OP_VERIFY: return fc_pkg::FC_XFER;
      default: return fc_pkg::FC_INVALID;
    endcase
  endfunction

  function automatic logic [3:0] cmd_len(input fc_pkg::fc_cmd_t k);
    case (k)
      fc_pkg::FC_SEEK, fc_pkg::FC_SPECIFY: return fc_pkg::FC_LEN_3;
      fc_pkg::FC_RECAL, fc_pkg::FC_SENSE_DRV, fc_pkg::FC_READ_ID,
      fc_pkg::FC_PERP: return fc_pkg::FC_LEN_2;
      fc_pkg::FC_CONFIGURE: return fc_pkg::FC_LEN_4;
      fc_pkg::FC_FORMAT: return fc_pkg::FC_LEN_6;
      fc_pkg::FC_XFER: return fc_pkg::FC_LEN_9;
      default: return fc_pkg::FC_LEN_1;
    endcase
  endfunction

  // Drive status pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wp_m <= 4'h0;
      wp_s <= 4'h0;
      rdy_m <= 4'h0;
      rdy_s <= 4'h0;
      t0_m <= 4'h0;
      t0_s <= 4'h0;
    end else begin
      wp_m <= write_protect_pin;
      wp_s <= wp_m;
      rdy_m <= drive_ready_pin;
      rdy_s <= rdy_m;
      t0_m <= track_zero_pin;
      t0_s <= t0_m;
    end
  end

  // Select bits steer only internal state, never the drive pins
  assign sel_drv = prm_r[fc_pkg::FC_IX_SEL][1:0];
  assign sel_head = prm_r[fc_pkg::FC_IX_SEL][2];

  always_comb begin
    state_nxt = state_r;
    prm_nxt = prm_r;
    res_nxt = res_r;
    pcn_nxt = pcn_r;
    kind_nxt = kind_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    idx_nxt = idx_r;
    spec1_nxt = spec1_r;
    spec2_nxt = spec2_r;
    cfg_nxt = cfg_r;
    pretrk_nxt = pretrk_r;
    perp_nxt = perp_r;
    sc_nxt = sc_r;
    eot_nxt = eot_r;
    st0p_nxt = st0p_r;
    seek_cyl_nxt = seek_cyl_r;
    last_fmt_nxt = last_fmt_r;
    lock_nxt = lock_r;
    pend_nxt = pend_r;
    go_xfer_nxt = go_xfer_r;
    drv_nxt = drv_r;
    pdrv_nxt = pdrv_r;
    settle_nxt = settle_r;
    unique case (state_r)
      S_IDLE: begin
        if (cmd_wr) begin
          prm_nxt[fc_pkg::FC_IX_OP] = cmd_data;
          kind_nxt = classify(cmd_data);
          len_nxt = cmd_len(classify(cmd_data));
          cnt_nxt = fc_pkg::FC_LEN_1;
          state_nxt = (cmd_len(classify(cmd_data)) == fc_pkg::FC_LEN_1) ?
                      S_DISPATCH : S_PARAM;
        end
      end
      S_PARAM: begin
        if (cmd_wr) begin
          prm_nxt[cnt_r] = cmd_data;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r + 4'h1 == len_r) state_nxt = S_DISPATCH;
        end
      end
      S_DISPATCH: begin
        idx_nxt = 4'h0;
        cnt_nxt = fc_pkg::FC_LEN_1;
        state_nxt = S_RES;
        drv_nxt = sel_drv;
        go_xfer_nxt = 1'b0;
        unique case (kind_r)
          fc_pkg::FC_INVALID: res_nxt[0] = fc_pkg::FC_ST0_INVALID;
          fc_pkg::FC_SEEK, fc_pkg::FC_RECAL: begin
            seek_cyl_nxt = (kind_r == fc_pkg::FC_SEEK) ?
              prm_r[fc_pkg::FC_IX_CYL] : fc_pkg::FC_ZERO_BYTE;
            state_nxt = S_SEEK;
          end
          fc_pkg::FC_SENSE_INT: begin
            if (pend_r) begin
              res_nxt[0] = st0p_r;
              res_nxt[1] = pcn_r[pdrv_r];
              cnt_nxt = fc_pkg::FC_LEN_2;
              pend_nxt = 1'b0;
            end else begin
              res_nxt[0] = fc_pkg::FC_ST0_INVALID;
            end
          end
          fc_pkg::FC_SENSE_DRV:
            res_nxt[0] = {1'b0, wp_s[sel_drv], rdy_s[sel_drv],
                          t0_s[sel_drv], 1'b0, sel_head, sel_drv};
          fc_pkg::FC_SPECIFY: begin
            spec1_nxt = prm_r[1];
            spec2_nxt = prm_r[2];
            state_nxt = S_IDLE;
          end
          fc_pkg::FC_CONFIGURE: begin
            cfg_nxt = prm_r[fc_pkg::FC_IX_CFG];
            pretrk_nxt = prm_r[fc_pkg::FC_IX_PRETRK];
            state_nxt = S_IDLE;
          end
          fc_pkg::FC_READ_ID: state_nxt = S_EXEC;
          fc_pkg::FC_LOCK: begin
            lock_nxt = prm_r[fc_pkg::FC_IX_OP][7];
            res_nxt[0] = {3'h0, prm_r[fc_pkg::FC_IX_OP][7], 4'h0};
          end
          fc_pkg::FC_DUMPREG: begin
            res_nxt[0] = pcn_r[0];
            res_nxt[1] = pcn_r[1];
            res_nxt[2] = pcn_r[2];
            res_nxt[3] = pcn_r[3];
            res_nxt[4] = spec1_r;
            res_nxt[5] = spec2_r;
            res_nxt[6] = last_fmt_r ? sc_r : eot_r;
            res_nxt[7] = {lock_r, 1'b0, perp_r[5:0]};
            res_nxt[8] = cfg_r;
            res_nxt[9] = pretrk_r;
            cnt_nxt = fc_pkg::FC_RES_DUMP;
          end
          fc_pkg::FC_PERP: begin
            perp_nxt = prm_r[1];
            state_nxt = S_IDLE;
          end
          fc_pkg::FC_VERSION: res_nxt[0] = fc_pkg::FC_VERSION_ID;
          fc_pkg::FC_FORMAT: begin
            sc_nxt = prm_r[fc_pkg::FC_IX_FMT_SC];
            last_fmt_nxt = 1'b1;
            settle_nxt = 23'(spec2_r[7:1] * SETTLE_UNIT_CYC);
            state_nxt = S_SETTLE;
          end
          fc_pkg::FC_XFER: begin
            eot_nxt = prm_r[fc_pkg::FC_IX_EOT];
            last_fmt_nxt = 1'b0;
            seek_cyl_nxt = prm_r[fc_pkg::FC_IX_CYL];
            settle_nxt = 23'(spec2_r[7:1] * SETTLE_UNIT_CYC);
            if (cfg_r[6] && prm_r[fc_pkg::FC_IX_CYL] != pcn_r[sel_drv]) begin
              go_xfer_nxt = 1'b1;
              state_nxt = S_SEEK;
            end else begin
              state_nxt = S_SETTLE;
            end
          end
        endcase
      end
      S_SEEK: begin
        if (seek_done || seek_fail) begin
          pcn_nxt[drv_r] = seek_done ? seek_cyl_r : seek_fail_cyl;
          if (go_xfer_r && seek_done) begin
            state_nxt = S_SETTLE;
          end else if (go_xfer_r) begin
            // Failed implied seek ends the transfer with abnormal-termination results
            res_nxt[0] = fc_pkg::FC_ST0_ABNORMAL | fc_pkg::FC_ST0_SEEK_END |
                         {5'h0, sel_head, drv_r};
            res_nxt[1] = fc_pkg::FC_ZERO_BYTE;
            res_nxt[2] = fc_pkg::FC_ZERO_BYTE;
            res_nxt[3] = seek_fail_cyl;
            res_nxt[4] = prm_r[fc_pkg::FC_IX_HEAD];
            res_nxt[5] = prm_r[fc_pkg::FC_IX_SEC];
            res_nxt[6] = prm_r[fc_pkg::FC_IX_SIZE];
            cnt_nxt = fc_pkg::FC_RES_XFER;
            state_nxt = S_RES;
          end else begin
            pend_nxt = 1'b1;
            pdrv_nxt = drv_r;
            st0p_nxt = fc_pkg::FC_ST0_SEEK_END |
                       (seek_fail ? fc_pkg::FC_ST0_ABNORMAL :
                        fc_pkg::FC_ZERO_BYTE) | {5'h0, sel_head, drv_r};
            state_nxt = S_IDLE;
          end
        end
      end
      S_SETTLE: begin
        // Settle wait precedes any ID search of the transfer
        if (settle_r == 23'h0) state_nxt = S_EXEC;
        else settle_nxt = settle_r - 23'h1;
      end
      S_EXEC: begin
        if (exec_done) begin
          res_nxt[0] = exec_st0;
          res_nxt[1] = exec_st1;
          res_nxt[2] = exec_st2;
          res_nxt[3] = exec_c;
          res_nxt[4] = exec_h;
          res_nxt[5] = exec_r;
          res_nxt[6] = exec_n;
          cnt_nxt = fc_pkg::FC_RES_XFER;
          pcn_nxt[drv_r] = (kind_r == fc_pkg::FC_FORMAT) ?
                           pcn_r[drv_r] : exec_c;
          state_nxt = S_RES;
        end
      end
      S_RES: begin
        if (res_rd) begin
          idx_nxt = idx_r + 4'h1;
          if (idx_r + 4'h1 == cnt_r) state_nxt = S_IDLE;
        end
      end
    endcase
    res_data_nxt = res_nxt[idx_nxt];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      for (int i = 0; i < 9; i++) prm_r[i] <= 8'h00;
      for (int i = 0; i < 10; i++) res_r[i] <= 8'h00;
      for (int i = 0; i < 4; i++) pcn_r[i] <= 8'h00;
      kind_r <= fc_pkg::FC_INVALID;
      cnt_r <= 4'h0;
      len_r <= 4'h0;
      idx_r <= 4'h0;
      spec1_r <= 8'h00;
      spec2_r <= 8'h00;
      cfg_r <= 8'h00;
      pretrk_r <= 8'h00;
      perp_r <= 8'h00;
      sc_r <= 8'h00;
      eot_r <= 8'h00;
      st0p_r <= 8'h00;
      res_data_r <= 8'h00;
      seek_cyl_r <= 8'h00;
      last_fmt_r <= 1'b0;
      lock_r <= 1'b0;
      pend_r <= 1'b0;
      go_xfer_r <= 1'b0;
      drv_r <= 2'h0;
      pdrv_r <= 2'h0;
      settle_r <= 23'h0;
    end else begin
      state_r <= state_nxt;
      prm_r <= prm_nxt;
      res_r <= res_nxt;
      pcn_r <= pcn_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      idx_r <= idx_nxt;
      spec1_r <= spec1_nxt;
      spec2_r <= spec2_nxt;
      cfg_r <= cfg_nxt;
      pretrk_r <= pretrk_nxt;
      perp_r <= perp_nxt;
      sc_r <= sc_nxt;
      eot_r <= eot_nxt;
      st0p_r <= st0p_nxt;
      res_data_r <= res_data_nxt;
      seek_cyl_r <= seek_cyl_nxt;
      last_fmt_r <= last_fmt_nxt;
      lock_r <= lock_nxt;
      pend_r <= pend_nxt;
      go_xfer_r <= go_xfer_nxt;
      drv_r <= drv_nxt;
      pdrv_r <= pdrv_nxt;
      settle_r <= settle_nxt;
    end
  end

  // Writes are refused while results are still owed to the host
  assign cmd_ready = (state_r == S_IDLE) || (state_r == S_PARAM);
  assign res_avail = (state_r == S_RES);
  assign res_data = res_data_r;
  assign ctrl_busy = (state_r != S_IDLE);
  assign drive_busy = (state_r == S_SEEK) ? 4'(1 << drv_r) : 4'h0;
  assign int_pending = pend_r;
  assign seek_req = (state_r == S_SEEK);
  assign seek_drive = drv_r;
  assign seek_cyl = seek_cyl_r;
  assign exec_req = (state_r == S_EXEC);
  assign exec_opcode = prm_r[fc_pkg::FC_IX_OP];
  assign exec_select = prm_r[fc_pkg::FC_IX_SEL];
  assign exec_cyl = prm_r[fc_pkg::FC_IX_CYL];
  assign exec_head = prm_r[fc_pkg::FC_IX_HEAD];
  assign exec_sector = prm_r[fc_pkg::FC_IX_SEC];
  assign exec_size = prm_r[fc_pkg::FC_IX_SIZE];
  assign exec_final = prm_r[fc_pkg::FC_IX_EOT];
  assign implied_seek_enable = cfg_r[6];
  assign config_byte = cfg_r;
  assign step_rate_time = spec1_r[7:4];
  assign head_load_time = spec2_r[7:1];
  assign lock_state = lock_r;
endmodule
`default_nettype wire

// *** inc/fc_pkg.sv ***
/*
 * Shared constants for the floppy controller command interpreter:
 * opcodes, status byte values, parameter byte positions, timing.
 * Assumes a 125 MHz controller clock.
 */
package fc_pkg;
  typedef enum logic [3:0] {
    FC_INVALID, FC_SEEK, FC_RECAL, FC_SENSE_INT, FC_SENSE_DRV, FC_SPECIFY,
    FC_CONFIGURE, FC_READ_ID, FC_LOCK, FC_DUMPREG, FC_PERP, FC_VERSION,
    FC_FORMAT, FC_XFER
  } fc_cmd_t;

  localparam logic [7:0] FC_OP_SEEK = 8'h0f;
  localparam logic [7:0] FC_OP_RECAL = 8'h07;
  localparam logic [7:0] FC_OP_SENSE_INT = 8'h08;
  localparam logic [7:0] FC_OP_SENSE_DRV = 8'h04;
  localparam logic [7:0] FC_OP_SPECIFY = 8'h03;
  localparam logic [7:0] FC_OP_CONFIGURE = 8'h13;
  localparam logic [7:0] FC_OP_DUMPREG = 8'h0e;
  localparam logic [7:0] FC_OP_PERP = 8'h12;
  localparam logic [7:0] FC_OP_VERSION = 8'h10;
  localparam logic [6:0] FC_OP_LOCK = 7'h14;
  localparam logic [5:0] FC_OP_READ_ID = 6'h0a;
  localparam logic [5:0] FC_OP_FORMAT = 6'h0d;
  localparam logic [4:0] FC_OP_READ = 5'h06;
  localparam logic [4:0] FC_OP_READ_DEL = 5'h0c;
  localparam logic [4:0] FC_OP_WRITE = 5'h05;
  localparam logic [4:0] FC_OP_WRITE_DEL = 5'h09;
  localparam logic [4:0] FC_OP_READ_TRK = 5'h02;
  localparam logic [4:0] FC_OP_VERIFY = 5'h16;

  localparam logic [7:0] FC_ST0_INVALID = 8'h80;
  localparam logic [7:0] FC_ST0_ABNORMAL = 8'h40;
  localparam logic [7:0] FC_ST0_SEEK_END = 8'h20;
  localparam logic [7:0] FC_VERSION_ID = 8'h90;
  localparam logic [7:0] FC_ZERO_BYTE = 8'h00;

  // Total bytes per command, opcode included; last two are result byte counts
  localparam logic [3:0] FC_LEN_1 = 4'h1;
  localparam logic [3:0] FC_LEN_2 = 4'h2;
  localparam logic [3:0] FC_LEN_3 = 4'h3;
  localparam logic [3:0] FC_LEN_4 = 4'h4;
  localparam logic [3:0] FC_LEN_6 = 4'h6;
  localparam logic [3:0] FC_LEN_9 = 4'h9;
  localparam logic [3:0] FC_RES_XFER = 4'h7;
  localparam logic [3:0] FC_RES_DUMP = 4'ha;

  // Parameter byte positions
  localparam int FC_IX_OP = 0;
  localparam int FC_IX_SEL = 1;
  localparam int FC_IX_CYL = 2;
  localparam int FC_IX_HEAD = 3;
  localparam int FC_IX_SEC = 4;
  localparam int FC_IX_SIZE = 5;
  localparam int FC_IX_EOT = 6;
  localparam int FC_IX_CFG = 2;
  localparam int FC_IX_PRETRK = 3;
  localparam int FC_IX_FMT_SC = 3;

  // Head settle unit per programmed count
  localparam int FC_CLK_NS = 8;
  localparam int FC_SETTLE_UNIT_NS = 1000;
  localparam int FC_SETTLE_UNIT_CYC =
    (FC_SETTLE_UNIT_NS + FC_CLK_NS - 1) / FC_CLK_NS;
endpackage

// *** test/fc_cmd_core_props.sv ***
/*
 * Concurrent checks on the command core's ports.
 * Assumes one ref_clk domain and an active-low asynchronous resetn.
 */
`timescale 1ns/1ps
`default_nettype none
module fc_cmd_core_props #(
  parameter int SETTLE_UNIT_CYC = 2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic res_rd,
  input wire logic res_avail,
  input wire logic [7:0] res_data,
  input wire logic ctrl_busy,
  input wire logic [3:0] drive_busy,
  input wire logic int_pending,
  input wire logic seek_req,
  input wire logic [1:0] seek_drive,
  input wire logic [7:0] seek_cyl,
  input wire logic seek_done,
  input wire logic seek_fail,
  input wire logic exec_req,
  input wire logic [7:0] exec_opcode,
  input wire logic [6:0] head_load_time
);
  logic [15:0] gap_r, gap_nxt;
  logic op_take;
  assign op_take = cmd_wr && cmd_ready && !ctrl_busy;
  // Quiet cycles since the last byte or seek, the room left for settling
  always_comb begin
    gap_nxt = gap_r + 16'h0001;
    if (!ctrl_busy || seek_req || exec_req || (cmd_wr && cmd_ready)) begin
      gap_nxt = 16'h0000;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 16'h0000;
    end else begin
      gap_r <= gap_nxt;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_result_blocks_cmd;
    res_avail |-> !cmd_ready;
  endproperty
  a_result_blocks_cmd: assert property (p_result_blocks_cmd)
    else $error("command path open during result phase");
  property p_invalid_byte;
    (op_take && cmd_data == 8'h1f) |-> ##2 (res_avail && res_data == 8'h80);
  endproperty
  a_invalid_byte: assert property (p_invalid_byte)
    else $error("unknown opcode did not answer 80");
  property p_invalid_single;
    (op_take && cmd_data == 8'h1f) ##2 res_avail ##1 res_rd |=> !res_avail;
  endproperty
  a_invalid_single: assert property (p_invalid_single)
    else $error("unknown opcode gave more than one byte");
  property p_sense_int;
    (op_take && cmd_data == 8'h08 && int_pending) |->
      ##2 (res_avail && res_data[5]);
  endproperty
  a_sense_int: assert property (p_sense_int)
    else $error("sense interrupt lacks seek end status");
  property p_busy_bit;
    seek_req |-> drive_busy == (4'h1 << seek_drive);
  endproperty
  a_busy_bit: assert property (p_busy_bit)
    else $error("drive busy bit wrong during seek");
  property p_seek_stable;
    (seek_req && $past(seek_req)) |->
      ($stable(seek_cyl) && $stable(seek_drive));
  endproperty
  a_seek_stable: assert property (p_seek_stable)
    else $error("seek target changed mid seek");
  property p_seek_ends;
    (seek_req && (seek_done || seek_fail)) |=> !seek_req;
  endproperty
  a_seek_ends: assert property (p_seek_ends)
    else $error("seek request held after answer");
  property p_no_overlap;
    exec_req |-> (!seek_req && ctrl_busy);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("transfer runs during seek");
  property p_settle;
    ($rose(exec_req) && exec_opcode[4:0] == 5'h06) |->
      gap_r >= head_load_time * SETTLE_UNIT_CYC;
  endproperty
  a_settle: assert property (p_settle)
    else $error("read began before head settle time");
  c_seek_done: cover property (seek_req && seek_done);
  c_seek_fail: cover property (seek_req && seek_fail);
  c_implied: cover property ($fell(seek_req) ##[1:40] $rose(exec_req));
endmodule
`default_nettype wire

// *** test/fc_drive_model.sv ***
/*
 * Positioner and transfer engine stand-in for the command core.
 * Assumes the core's ref_clk; slow and fail_seek come from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module fc_drive_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic fail_seek,
  input wire logic seek_req,
  input wire logic exec_req,
  input wire logic [7:0] exec_opcode,
  input wire logic [7:0] exec_select,
  input wire logic [7:0] exec_cyl,
  input wire logic [7:0] exec_head,
  input wire logic [7:0] exec_sector,
  input wire logic [7:0] exec_size,
  output logic seek_done,
  output logic seek_fail,
  output logic [7:0] seek_fail_cyl,
  output logic exec_done,
  output logic [7:0] exec_st0,
  output logic [7:0] exec_st1,
  output logic [7:0] exec_st2,
  output logic [7:0] exec_c,
  output logic [7:0] exec_h,
  output logic [7:0] exec_r,
  output logic [7:0] exec_n
);
  logic [4:0] cnt_r;
  logic fired_r, rid;
  logic [7:0] tog_r;
  assign rid = exec_opcode[5:0] == 6'h0a;
  // Outside the answer cycle the bytes churn, so stale values never match
  assign seek_fail_cyl = seek_fail ? 8'h27 : tog_r;
  assign exec_st0 = exec_done ? {5'h00, exec_select[2:0]} : tog_r;
  assign exec_st1 = exec_done ? 8'h00 : tog_r;
  assign exec_st2 = exec_done ? 8'h00 : ~tog_r;
  assign exec_c = exec_done ? (rid ? 8'h11 : exec_cyl) : tog_r;
  assign exec_h = exec_done ? (rid ? 8'h01 : exec_head) : ~tog_r;
  assign exec_r = exec_done ? (rid ? 8'h07 : exec_sector) : tog_r;
  assign exec_n = exec_done ? (rid ? 8'h02 : exec_size) : ~tog_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 5'h00;
      fired_r <= 1'b0;
      tog_r <= 8'h00;
      seek_done <= 1'b0;
      seek_fail <= 1'b0;
      exec_done <= 1'b0;
    end else begin
      tog_r <= tog_r + 8'h5b;
      seek_done <= 1'b0;
      seek_fail <= 1'b0;
      exec_done <= 1'b0;
      if (!seek_req && !exec_req) begin
        cnt_r <= 5'h00;
        fired_r <= 1'b0;
      end else if (!fired_r && cnt_r == (slow ? 5'h14 : 5'h01)) begin
        fired_r <= 1'b1;
        seek_done <= seek_req && !fail_seek;
        seek_fail <= seek_req && fail_seek;
        exec_done <= exec_req && !seek_req;
      end else if (!fired_r) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/fc_cmd_core_tb.sv ***
/*
 * Self-checking bench for the command core with the drive model.
 * Assumes host strobes on ref_clk; drive pins change well before use.
 */
`timescale 1ns/1ps
`default_nettype none
module fc_cmd_core_tb;
  localparam int UNIT = 2;
  logic ref_clk, resetn, cmd_wr, res_rd, slow, fail_seek;
  logic cmd_ready, res_avail, ctrl_busy, int_pending, seek_req, seek_done;
  logic seek_fail, exec_req, exec_done, implied_seek_enable, lock_state;
  logic [1:0] seek_drive;
  logic [3:0] write_protect_pin, drive_ready_pin, track_zero_pin;
  logic [3:0] drive_busy, step_rate_time;
  logic [6:0] head_load_time;
  logic [7:0] cmd_data, res_data, seek_cyl, seek_fail_cyl, exec_opcode;
  logic [7:0] exec_select, exec_cyl, exec_head, exec_sector, exec_size;
  logic [7:0] exec_final, exec_st0, exec_st1, exec_st2, exec_c, exec_h;
  logic [7:0] exec_r, exec_n, config_byte, last_seek_cyl;
  int fail_count = 0;
  int samples_checked = 0;
  fc_cmd_core #(.SETTLE_UNIT_CYC(UNIT)) dut (.*);
  fc_drive_model u_drive (.*);
  always @(posedge ref_clk) if (seek_req) last_seek_cyl <= seek_cyl;
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] b[$]);
    int t;
    for (t = 0; t < 400 && cmd_ready !== 1'b1; t++) @(posedge ref_clk);
    foreach (b[i]) begin
      cmd_wr <= 1'b1;
      cmd_data <= b[i];
      @(posedge ref_clk);
    end
    cmd_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic expect_res(input string what, input logic [7:0] e[$]);
    int t;
    for (t = 0; t < 400 && res_avail !== 1'b1; t++) @(posedge ref_clk);
    check({what, " avail"}, {7'h00, res_avail}, 8'h01);
    foreach (e[i]) begin
      res_rd <= 1'b1;
      @(posedge ref_clk);
      check(what, res_data, e[i]);
    end
    res_rd <= 1'b0;
    @(posedge ref_clk);
    check({what, " end"}, {7'h00, res_avail}, 8'h00);
  endtask
  task automatic xfer(input string what, input logic [7:0] op, cyl, st0, c);
    send('{op, 8'h01, cyl, 8'h00, 8'h03, 8'h02, 8'h09, 8'h1b, 8'hff});
    expect_res(what, '{st0, 8'h00, 8'h00, c, 8'h00, 8'h03, 8'h02});
  endtask
  task automatic dump(input logic [7:0] pcn1, sc_eot);
    send('{8'h0e});
    expect_res("dump", '{8'h00, pcn1, 8'h00, 8'h00, 8'ha5, 8'h04, sc_eot,
      8'h80, 8'h40, 8'h07});
  endtask
  task automatic t_invalid();
    send('{8'h1f});
    cmd_wr <= 1'b1;
    cmd_data <= 8'h08;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
    expect_res("invalid", '{8'h80});
    repeat (4) @(posedge ref_clk);
    check("refused byte", {7'h00, res_avail}, 8'h00);
    check("ready", {7'h00, cmd_ready}, 8'h01);
    $display("test invalid done");
  endtask
  task automatic t_setup();
    send('{8'h03, 8'ha5, 8'h04});
    send('{8'h13, 8'h00, 8'h40, 8'h07});
    send('{8'h94});
    expect_res("lock", '{8'h10});
    check("step rate", {4'h0, step_rate_time}, 8'h0a);
    check("head load", {1'b0, head_load_time}, 8'h02);
    check("config", config_byte, 8'h40);
    check("implied", {7'h00, implied_seek_enable}, 8'h01);
    check("lock bit", {7'h00, lock_state}, 8'h01);
    $display("test setup done");
  endtask
  task automatic t_seek();
    int t;
    slow <= 1'b1;
    send('{8'h0f, 8'h05, 8'h22});
    for (t = 0; t < 400 && int_pending !== 1'b1; t++) @(posedge ref_clk);
    slow <= 1'b0;
    send('{8'h08});
    expect_res("sense int", '{8'h25, 8'h22});
    check("int clear", {7'h00, int_pending}, 8'h00);
    $display("test seek done");
  endtask
  task automatic t_sense_drv();
    write_protect_pin <= 4'b0100;
    drive_ready_pin <= 4'b0101;
    track_zero_pin <= 4'b0001;
    repeat (4) @(posedge ref_clk);
    send('{8'h04, 8'h00});
    expect_res("drive 0", '{8'h30});
    send('{8'h04, 8'h06});
    expect_res("drive 2", '{8'h66});
    $display("test sense drive done");
  endtask
  task automatic t_xfer();
    logic [7:0] ops[$];
    ops = '{8'h46, 8'h45, 8'h56};
    foreach (ops[i]) xfer("layout", ops[i], 8'h22, 8'h01, 8'h22);
    check("final", exec_final, 8'h09);
    dump(8'h22, 8'h09);
    xfer("implied seek", 8'h46, 8'h30, 8'h01, 8'h30);
    check("seek cyl", last_seek_cyl, 8'h30);
    fail_seek <= 1'b1;
    xfer("seek fail", 8'h46, 8'h40, 8'h61, 8'h27);
    fail_seek <= 1'b0;
    slow <= 1'b1;
    send('{8'h4a, 8'h01});
    expect_res("read id",
      '{8'h01, 8'h00, 8'h00, 8'h11, 8'h01, 8'h07, 8'h02});
    slow <= 1'b0;
    send('{8'h4d, 8'h01, 8'h02, 8'h12, 8'h1b, 8'he5});
    expect_res("format", '{8'h01, 8'h00, 8'h00, 8'h02, 8'h12, 8'h1b, 8'he5});
    dump(8'h11, 8'h12);
    $display("test transfer done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    resetn = 1'b0;
    cmd_wr = 1'b0;
    cmd_data = 8'h00;
    res_rd = 1'b0;
    slow = 1'b0;
    fail_seek = 1'b0;
    write_protect_pin = 4'h0;
    drive_ready_pin = 4'h0;
    track_zero_pin = 4'h0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_invalid();
    t_setup();
    t_seek();
    t_sense_drv();
    t_xfer();
    print_verdict();
  end
endmodule
bind fc_cmd_core fc_cmd_core_props #(.SETTLE_UNIT_CYC(SETTLE_UNIT_CYC))
  u_props (.*);
`default_nettype wire
